// ===== csspt_regs.svh
// register offsets, field positions, reset values and timing counts for the serial port
// ==========================================================================
`ifndef CSSPT_REGS_SVH
`define CSSPT_REGS_SVH
// ==========================================================================
// register offsets
`define CSSPT_PORT_MODE_A_ADDR   7'h04
`define CSSPT_SERIAL_MODE_ADDR   7'h05
`define CSSPT_SHIFT_LOW_ADDR     7'h06
`define CSSPT_SHIFT_HIGH_ADDR    7'h07
`define CSSPT_PIN_BUFFER_ADDR    7'h0c
`define CSSPT_PORT_MODE_C_ADDR   7'h25
`define CSSPT_STATUS_ADDR        7'h30
// ==========================================================================
// field positions
`define CSSPT_CLOCK_PIN_BIT      3
`define CSSPT_RECEIVE_PIN_BIT    1
`define CSSPT_TRANSMIT_PIN_BIT   0
`define CSSPT_IDLE_LEVEL_BIT     1
`define CSSPT_DIVISOR_BIT        0
`define CSSPT_OPEN_DRAIN_BIT     2
// ==========================================================================
// reset values and codes
`define CSSPT_NIBBLE_RESET       4'h0
`define CSSPT_COUNT_RESET        3'h0
`define CSSPT_COUNT_LAST         3'h7
`define CSSPT_SEL_SYSTEM         3'h6
`define CSSPT_SEL_EXTERNAL       3'h7
`define CSSPT_PRESCALE_WIDTH     12
`endif

// ===== csspt_pkg.sv
// types shared by the clocked serial port
package csspt_pkg;
    // ======================================================================
    // operating states, gray coded along wait start, wait clock, transfer
    typedef enum logic [1:0]
    {
        CSSPT_WAIT_START = 2'b00,
        CSSPT_WAIT_CLOCK = 2'b01,
        CSSPT_TRANSFER   = 2'b11,
        CSSPT_CONTINUOUS = 2'b10
    } csspt_state_type;
    // ======================================================================
    // register bus request bundle
    typedef struct packed
    {
        logic [6:0] addr;
        logic [3:0] wdata;
        logic       wr;
        logic       rd;
    } csspt_bus_type;
    // ======================================================================
    // pin bundle for one shared pin: output and enable (low drives)
    typedef struct packed
    {
        logic value;
        logic oe_n;
    } csspt_pin_type;
endpackage

// ===== csspt_serial_port.sv
// clock synchronous eight bit serial port with registers, clock select and pins
//
// Design decision made here: the strobed register port.
`include "csspt_regs.svh"
module csspt_serial_port
    import csspt_pkg::*;
#(
    parameter int PRESCALE_WIDTH = `CSSPT_PRESCALE_WIDTH
)
(
    input  wire logic          clock_in,      // peripheral clock
    input  wire logic          rst_in,        // synchronous reset, active high
    input  wire logic          stop_in,       // stop mode initialisation, level
    input  wire csspt_bus_type bus_in,        // register bus request
    output logic [3:0]         rdata_out,     // read data, cycle after read
    input  wire logic          start_in,      // transfer start instruction pulse
    input  wire logic          sck_in,        // clock pin level in
    output csspt_pin_type      sck_out,       // clock pin drive
    input  wire logic          si_in,         // receive data pin
    output csspt_pin_type      so_out,        // transmit data pin drive
    output logic               port_sck_out,  // pin owned by port when high
    output logic               port_si_out,   // receive pin owned by port
    output logic               port_so_out,   // transmit pin owned by port
    output logic               irq_flag_out,  // serial interrupt flag pulse
    output logic [1:0]         state_out      // current operating state
);
    // ======================================================================
    // registers
    logic [3:0]      serial_mode;     // clock pin switch and clock select
    logic [1:0]      port_mode_a;     // receive and transmit switches
    logic            idle_level;      // transmit idle level
    logic            divisor_sel;     // tap divisor two or four
    logic            open_drain;      // transmit buffer type
    logic [7:0]      shift_data;      // data shift register, no reset
    logic [2:0]      bit_counter;     // octal bit counter
    csspt_state_type state;           // operating state
    logic            so_level;        // transmit output level
    logic            sck_level;       // internal clock output level
    logic [PRESCALE_WIDTH-1:0] prescale; // free running prescaler
    logic [1:0]      half_div;        // tap sub divider
    logic            ext_prev;        // previous external clock level
    logic            done_pulse;      // transfer end or abort
    // ======================================================================
    // decoded strobes
    logic mode_wr;
    logic init_all;
    logic external;
    logic tap_tick;
    logic edge_tick;
    logic fall_edge;
    logic rise_edge;
    assign mode_wr  = bus_in.wr && (bus_in.addr == `CSSPT_SERIAL_MODE_ADDR);
    assign init_all = rst_in || stop_in;
    assign external = (serial_mode[2:0] == `CSSPT_SEL_EXTERNAL);

    // tap index: code 0 divides by 2048 (bit 10), code 5 by 2 (bit 0)
    function automatic logic tap_of(input logic [2:0] sel,
                                    input logic [PRESCALE_WIDTH-1:0] cnt);
        logic [PRESCALE_WIDTH-1:0] mask;
        mask = '0;
        case (sel)
            3'h0:    mask[10:0] = '1;
            3'h1:    mask[8:0]  = '1;
            3'h2:    mask[6:0]  = '1;
            3'h3:    mask[4:0]  = '1;
            3'h4:    mask[2:0]  = '1;
            default: mask[0]    = 1'b1;
        endcase
        tap_of = ((cnt & mask) == mask);
    endfunction

    // ======================================================================
    // prescaler, always running so taps are periodic
    always_ff @(posedge clock_in)
    begin
        if (init_all)
            prescale <= '0;
        else
            prescale <= prescale + 1'b1;
    end

    assign tap_tick = tap_of(serial_mode[2:0], prescale);

    // half period divider: a toggle every one or two taps gives /2 or /4
    always_ff @(posedge clock_in)
    begin
        if (init_all || mode_wr)
            half_div <= 2'h0;
        else if (tap_tick)
            half_div <= (divisor_sel && half_div == 2'h0) ? 2'h1 : 2'h0;
    end

    // internal edge events: each event toggles the clock level
    always_comb
    begin
        if (serial_mode[2:0] == `CSSPT_SEL_SYSTEM)
            edge_tick = 1'b1;
        else if (external)
            edge_tick = 1'b0;
        else
            edge_tick = tap_tick && (!divisor_sel || half_div == 2'h1);
    end

    // clock runs only while waiting, transferring or continuous
    logic clock_run;
    assign clock_run = (state != CSSPT_WAIT_START);

    always_ff @(posedge clock_in)
    begin
        if (init_all || mode_wr)
            sck_level <= 1'b1;
        else if (!clock_run || external)
            sck_level <= 1'b1;
        else if (edge_tick)
            sck_level <= !sck_level;
    end

    // external clock edge detection, pin taken as synchronous
    always_ff @(posedge clock_in)
    begin
        if (init_all)
            ext_prev <= 1'b1;
        else
            ext_prev <= sck_in;
    end

    // edges of the selected transfer clock
    always_comb
    begin
        if (external)
        begin
            fall_edge = ext_prev && !sck_in;
            rise_edge = !ext_prev && sck_in;
        end
        else
        begin
            fall_edge = clock_run && edge_tick && sck_level;
            rise_edge = clock_run && edge_tick && !sck_level;
        end
    end

    // ======================================================================
    // control registers; reset forces documented values on all but the idle level
    always_ff @(posedge clock_in)
    begin
        if (init_all)
            serial_mode <= `CSSPT_NIBBLE_RESET;
        else if (mode_wr)
            serial_mode <= bus_in.wdata;
    end

    always_ff @(posedge clock_in)
    begin
        if (init_all)
            port_mode_a <= 2'h0;
        else if (bus_in.wr && bus_in.addr == `CSSPT_PORT_MODE_A_ADDR)
            port_mode_a <= bus_in.wdata[1:0];
    end

    // idle level keeps its value over reset, left undefined by design
    always_ff @(posedge clock_in)
    begin
        if (init_all)
            divisor_sel <= 1'b0;
        else if (bus_in.wr && bus_in.addr == `CSSPT_PORT_MODE_C_ADDR)
            divisor_sel <= bus_in.wdata[`CSSPT_DIVISOR_BIT];
    end

    always_ff @(posedge clock_in)
    begin
        if (bus_in.wr && bus_in.addr == `CSSPT_PORT_MODE_C_ADDR)
            idle_level <= bus_in.wdata[`CSSPT_IDLE_LEVEL_BIT];
    end

    always_ff @(posedge clock_in)
    begin
        if (init_all)
            open_drain <= 1'b0;
        else if (bus_in.wr && bus_in.addr == `CSSPT_PIN_BUFFER_ADDR)
            open_drain <= bus_in.wdata[`CSSPT_OPEN_DRAIN_BIT];
    end

    // ======================================================================
    // state machine and bit counter
    always_ff @(posedge clock_in)
    begin
        done_pulse <= 1'b0;
        if (init_all)
        begin
            state       <= CSSPT_WAIT_START;
            bit_counter <= `CSSPT_COUNT_RESET;
        end
        else if (mode_wr)
        begin
            state       <= CSSPT_WAIT_START;
            bit_counter <= `CSSPT_COUNT_RESET;
            done_pulse  <= (state == CSSPT_TRANSFER);
        end
        else if (start_in && state != CSSPT_CONTINUOUS)
        begin
            bit_counter <= `CSSPT_COUNT_RESET;
            state       <= CSSPT_WAIT_CLOCK;
            done_pulse  <= (state == CSSPT_TRANSFER);
        end
        else
        begin
            unique case (state)
                CSSPT_WAIT_START: ;
                CSSPT_WAIT_CLOCK:
                    if (fall_edge)
                        state <= (port_mode_a == 2'h0 && !external)
                                 ? CSSPT_CONTINUOUS : CSSPT_TRANSFER;
                CSSPT_TRANSFER:
                    if (rise_edge)
                    begin
                        bit_counter <= bit_counter + 3'h1;
                        if (bit_counter == `CSSPT_COUNT_LAST)
                        begin
                            bit_counter <= `CSSPT_COUNT_RESET;
                            done_pulse  <= 1'b1;
                            state <= external ? CSSPT_WAIT_CLOCK
                                              : CSSPT_WAIT_START;
                        end
                    end
                CSSPT_CONTINUOUS: ;
            endcase
        end
    end

    // ======================================================================
    // data shift register; software writes are refused mid-transfer only by
    // contract, so a write here simply wins over the shift
    logic shifting;
    assign shifting = (state == CSSPT_TRANSFER) ||
                      (state == CSSPT_WAIT_CLOCK && port_mode_a != 2'h0);

    always_ff @(posedge clock_in)
    begin
        if (bus_in.wr && bus_in.addr == `CSSPT_SHIFT_LOW_ADDR)
            shift_data[3:0] <= bus_in.wdata;
        else if (bus_in.wr && bus_in.addr == `CSSPT_SHIFT_HIGH_ADDR)
            shift_data[7:4] <= bus_in.wdata;
        else if (state == CSSPT_TRANSFER && rise_edge)
            shift_data <= {si_in, shift_data[7:1]};
    end

    // transmit level: lsb on each falling edge while shifting, idle level on its write
    always_ff @(posedge clock_in)
    begin
        if (bus_in.wr && bus_in.addr == `CSSPT_PORT_MODE_C_ADDR)
            so_level <= bus_in.wdata[`CSSPT_IDLE_LEVEL_BIT];
        else if (shifting && fall_edge)
            so_level <= shift_data[0];
    end

    // ======================================================================
    // read port: registers are write only apart from data and status
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
            rdata_out <= 4'h0;
        else if (bus_in.rd)
        begin
            case (bus_in.addr)
                `CSSPT_SHIFT_LOW_ADDR:  rdata_out <= shift_data[3:0];
                `CSSPT_SHIFT_HIGH_ADDR: rdata_out <= shift_data[7:4];
                `CSSPT_STATUS_ADDR:     rdata_out <= {1'b0, bit_counter};
                default:                rdata_out <= 4'h0;
            endcase
        end
        else
            rdata_out <= 4'h0;
    end

    // ======================================================================
    // pin muxing
    always_comb
    begin
        port_sck_out  = !serial_mode[`CSSPT_CLOCK_PIN_BIT];
        port_si_out   = !port_mode_a[`CSSPT_RECEIVE_PIN_BIT];
        port_so_out   = !port_mode_a[`CSSPT_TRANSMIT_PIN_BIT];
        sck_out.value = sck_level;
        sck_out.oe_n  = !serial_mode[`CSSPT_CLOCK_PIN_BIT] || external;
        so_out.value  = so_level;
        // open drain releases the pin for a high level
        so_out.oe_n   = !port_mode_a[`CSSPT_TRANSMIT_PIN_BIT] ||
                        (open_drain && so_level);
    end

    assign irq_flag_out = done_pulse;
    assign state_out    = state;
endmodule // csspt_serial_port

// ===== csspt_serial_port_monitor.sv
// checker of pin, flag and bus timing seen at the serial port's ports
module csspt_serial_port_monitor
    import csspt_pkg::*;
#(
    parameter int PRESCALE_WIDTH = 12
)
(
    input wire logic          clock_in,
    input wire logic          rst_in,
    input wire logic          stop_in,
    input wire csspt_bus_type bus_in,
    input wire logic [3:0]    rdata_out,
    input wire logic          start_in,
    input wire logic          sck_in,
    input wire csspt_pin_type sck_out,
    input wire logic          si_in,
    input wire csspt_pin_type so_out,
    input wire logic          port_sck_out,
    input wire logic          port_si_out,
    input wire logic          port_so_out,
    input wire logic          irq_flag_out,
    input wire logic [1:0]    state_out
);
    logic [3:0] mode;  // shadow of serial mode register
    logic [1:0] pins;  // shadow of pin switch bits
    logic       odr;   // shadow of open drain select
    logic       idle;  // shadow of idle level bit
    // ======================================================================
    // shadows follow the bus so no design internals are needed
    always_ff @(posedge clock_in)
    begin
        if (rst_in || stop_in)
        begin
            mode <= 4'h0;
            pins <= 2'h0;
            odr  <= 1'b0;
        end
        else if (bus_in.wr)
        begin
            if (bus_in.addr == 7'h05) mode <= bus_in.wdata;
            if (bus_in.addr == 7'h04) pins <= bus_in.wdata[1:0];
            if (bus_in.addr == 7'h0c) odr <= bus_in.wdata[2];
        end
    end
    // idle level has no reset value, so it is only tracked from writes
    always_ff @(posedge clock_in)
    begin
        if (bus_in.wr && bus_in.addr == 7'h25) idle <= bus_in.wdata[1];
    end
    // ======================================================================
    // assertions
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in || stop_in);
    a_reset_pins: assert property (disable iff (stop_in) rst_in |=> sck_out.value
        && sck_out.oe_n && so_out.oe_n && !irq_flag_out && rdata_out == 4'h0)
        else $error("pins not idle after reset");
    a_rdata_quiet: assert property (!bus_in.rd |=> rdata_out == 4'h0)
        else $error("read data without read");
    a_irq_single: assert property (irq_flag_out |=> !irq_flag_out)
        else $error("flag longer than one cycle");
    a_irq_on_exit: assert property ((state_out == CSSPT_TRANSFER ##1
        state_out != CSSPT_TRANSFER) |-> ($past(irq_flag_out) || irq_flag_out)
        or (##1 irq_flag_out)) else $error("transfer left without flag");
    a_clock_pin_owner: assert property ($stable(mode) |-> port_sck_out == !mode[3])
        else $error("clock pin owner wrong");
    a_rx_pin_owner: assert property ($stable(pins) |-> port_si_out == !pins[1])
        else $error("receive pin owner wrong");
    a_tx_pin_owner: assert property ($stable(pins) |-> port_so_out == !pins[0])
        else $error("transmit pin owner wrong");
    a_clock_pin_dir: assert property ($stable(mode) && mode[3]
        |-> sck_out.oe_n == (mode[2:0] == 3'h7)) else $error("clock pin direction wrong");
    a_idle_level: assert property (bus_in.wr && bus_in.addr == 7'h25 && pins[0]
        |=> ##1 (so_out.oe_n == (odr && idle)) && (odr || so_out.value == idle))
        else $error("transmit pin idle level wrong");
    a_sck_idle_high: assert property (state_out == CSSPT_WAIT_START && $stable(mode)
        && $past(state_out) == CSSPT_WAIT_START && mode[3] && mode[2:0] != 3'h7
        |-> sck_out.value) else $error("clock output not idle high");
    c_flag: cover property (irq_flag_out);
    c_transfer: cover property (state_out == CSSPT_TRANSFER);
    c_external: cover property (mode == 4'hf && sck_out.oe_n);
endmodule // csspt_serial_port_monitor

bind csspt_serial_port csspt_serial_port_monitor #(.PRESCALE_WIDTH(PRESCALE_WIDTH)) u_mon
    (.clock_in, .rst_in, .stop_in, .bus_in, .rdata_out, .start_in, .sck_in, .sck_out,
     .si_in, .so_out, .port_sck_out, .port_si_out, .port_so_out, .irq_flag_out, .state_out);

// ===== csspt_peer.sv
// far side chip: shifts a byte out on falling clock, samples on rising clock
module csspt_peer
(
    input  wire logic       clock_in,  // bench clock, used to watch the pin
    input  wire logic       load_in,   // loads the byte and restarts the count
    input  wire logic [7:0] tx_in,     // byte to send, lsb first
    input  wire logic       sck_in,    // clock pin level
    input  wire logic       so_in,     // transmit pin level
    output logic            si_out,    // receive pin drive
    output logic [7:0]      rx_out     // byte collected from the port
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] txq;        // bits still to send
    logic [3:0] cnt = 4'h8; // bits received in this frame
    logic       prev = 1'b1;
    initial si_out = 1'b0;
    // ======================================================================
    // edges are found by sampling, as the pin is slow beside the bench clock
    always @(posedge clock_in)
    begin
        prev <= sck_in;
        if (load_in)
        begin
            txq <= tx_in;
            cnt <= 4'h0;
        end
        else if (prev && !sck_in && cnt < 4'h8)
        begin
            si_out <= txq[0];
            txq    <= {1'b0, txq[7:1]};
        end
        else if (!prev && sck_in && cnt < 4'h8)
        begin
            rx_out <= {so_in, rx_out[7:1]};
            cnt    <= cnt + 4'h1;
        end
        // outside a frame the line keeps moving so stale bits never match
        else if (cnt == 4'h8) si_out <= ~si_out;
    end
endmodule // csspt_peer

// ===== csspt_serial_port_tb_top.sv
// self-checking bench for the clocked serial port
module csspt_serial_port_tb_top import csspt_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic          clock_in, rst_in, stop_in, start_in, load, irq, port_sck;
    csspt_bus_type bus;           // register bus request
    logic [3:0]    rdata;         // read data
    csspt_pin_type sck, so;       // pin drives
    logic [1:0]    state;         // operating state
    logic [7:0]    rx;            // byte seen by the far side
    logic          si, sck_lvl, so_lvl;
    int            n_errors = 0;
    int            compares = 0;
    // pins idle at the pull-up level when nobody drives them
    assign sck_lvl = sck.oe_n ? 1'b1 : sck.value;
    assign so_lvl  = so.oe_n ? 1'b1 : so.value;
    csspt_serial_port #(.PRESCALE_WIDTH(12)) u_csspt_serial_port (.clock_in, .rst_in,
        .stop_in, .bus_in(bus), .rdata_out(rdata), .start_in, .sck_in(sck_lvl),
        .sck_out(sck), .si_in(si), .so_out(so), .port_sck_out(port_sck), .port_si_out(),
        .port_so_out(), .irq_flag_out(irq), .state_out(state));
    csspt_peer u_csspt_peer (.clock_in, .load_in(load), .tx_in(8'h3c), .sck_in(sck_lvl),
        .so_in(so_lvl), .si_out(si), .rx_out(rx));
    // ======================================================================
    // tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask
    task automatic wr(input logic [6:0] a, input logic [3:0] d);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock_in);
        bus <= '0;
    endtask
    task automatic rd(input logic [6:0] a, input logic [3:0] exp);
        bus <= '{addr: a, wdata: 4'h0, wr: 1'b0, rd: 1'b1};
        tick(1);
        bus <= '0;
        chk({4'h0, rdata}, {4'h0, exp});
    endtask
    // start pulse, with the far side optionally loaded for a frame
    task automatic go(input logic l);
        start_in <= 1'b1;
        load     <= l;
        @(posedge clock_in);
        start_in <= 1'b0;
        load     <= 1'b0;
    endtask
    task automatic wait_irq(input int lim);
        int i;
        i = 0;
        #1;
        while (irq !== 1'b1 && i < lim)
        begin
            tick(1);
            i++;
        end
        chk({7'h0, irq}, 8'h01);
    endtask
    // cycles between two falling clock edges
    task automatic period(input int exp);
        int   c;
        int   f1;
        logic p;
        c  = 0;
        f1 = -1;
        p  = sck.value;
        while (c < 600)
        begin
            tick(1);
            c++;
            if (p && !sck.value && f1 >= 0) break;
            if (p && !sck.value) f1 = c;
            p = sck.value;
        end
        chk(8'(c - f1), 8'(exp));
    endtask
    task automatic print_verdict();
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ======================================================================
    // clock and watchdog; the tests need well under 10000 cycles
    initial
    begin
        clock_in = 1'b0;
        forever #10 clock_in = ~clock_in;
    end
    initial
    begin
        repeat (20000) @(posedge clock_in);
        n_errors++;
        print_verdict();
    end
    // ======================================================================
    // main sequence
    initial
    begin
        rst_in   = 1'b1;
        stop_in  = 1'b0;
        start_in = 1'b0;
        load     = 1'b0;
        bus      = '0;
        repeat (3) @(posedge clock_in);
        rst_in <= 1'b0;
        tick(1);
        chk({6'h0, sck}, 8'h03);
        rd(7'h10, 4'h0);
        wr(7'h06, 4'h5);
        wr(7'h07, 4'ha);
        rd(7'h06, 4'h5);
        rd(7'h07, 4'ha);
        // idle level, push-pull then open drain
        wr(7'h04, 4'h1);
        wr(7'h25, 4'h2);
        tick(1);
        chk({6'h0, so}, 8'h02);
        wr(7'h0c, 4'h4);
        wr(7'h25, 4'h2);
        tick(1);
        chk({7'h0, so.oe_n}, 8'h01);
        wr(7'h25, 4'h0);
        tick(1);
        chk({6'h0, so}, 8'h00);
        wr(7'h0c, 4'h0);
        // full duplex frame on the fastest tap; the far side answers a pin edge
        // one cycle late, so a half period of two cycles keeps its bits in time
        wr(7'h04, 4'h3);
        wr(7'h05, 4'hd);
        wr(7'h06, 4'h5);
        wr(7'h07, 4'ha);
        go(1'b1);
        wait_irq(100);
        tick(4);
        chk(rx, 8'ha5);
        rd(7'h06, 4'hc);
        rd(7'h07, 4'h3);
        chk({6'h0, state}, 8'h00);
        chk({7'h0, port_sck}, 8'h00);
        // prescaler taps with both divisors, each aborted by a mode write
        for (int k = 0; k < 6; k++)
        begin
            wr(7'h25, 4'(k % 2));
            wr(7'h05, 4'(13 - k / 2));
            go(1'b0);
            period((4 << (2 * (k / 2))) << (k % 2));
            wr(7'h05, 4'(13 - k / 2));
            wait_irq(3);
            chk({6'h0, state}, 8'h00);
        end
        // stop mode forces the divisor back to two
        wr(7'h04, 4'h0);
        wr(7'h25, 4'h1);
        stop_in <= 1'b1;
        tick(1);
        stop_in <= 1'b0;
        wr(7'h05, 4'hd);
        go(1'b0);
        period(4);
        // leaving continuous output is no transfer end, so no flag follows
        wr(7'h05, 4'hd);
        tick(1);
        chk({7'h0, irq}, 8'h00);
        chk({6'h0, state}, 8'h00);
        // external clock makes the clock pin an input
        wr(7'h05, 4'hf);
        tick(2);
        chk({7'h0, sck.oe_n}, 8'h01);
        wr(7'h05, 4'h0);
        tick(2);
        chk({7'h0, port_sck}, 8'h01);
        print_verdict();
    end
endmodule // csspt_serial_port_tb_top
